/* File: design/shift_and_subtractive_adder.sv */
// Behaviour
// RQ1: Quotient-only left shift wraps bit 14 around.
// RQ2: Accumulator-only left shift wraps bit 14 around.
// RQ3: Double or muldiv quotient-left saves quotient bit 14.
// RQ4: Double shift: accumulator bit 14 enters quotient bit 0.
// RQ5: Timing chain clears accumulator-bit carry flag.
// RQ6: Saved quotient bit enters accumulator bit 0.
// RQ7: Chain recirculation clears the saved-bit flag.
// RQ8: Repeat one-place shifts until count reaches zero.
// RQ9: Multiply quotient-right captures quotient bit 0.
// RQ10: Multiply accumulator-right shift does not extend sign.
// RQ11: Divide quotient-left sets carry, forces bit 0 zero.
// RQ12: Adder is fifteen identical combinational stages.
// RQ13: Subtractive one's complement with end-around borrow.
// RQ14: Each stage forms independent per-bit difference first.
// RQ15: Borrows propagate upward and wrap until satisfied.
// RQ16: Result inverts difference where borrow row set.
// RQ17: Adder always combines exchange and operand registers.
// RQ18: Sum transfers only on adder-to-register commands.
// RQ19: Add subtracts operand's apparent complement from exchange.
// RQ20: Exchange clears to ones phase four, loads phase one.
// RQ21: Subtract enters operand complement into operand register.
// RQ22: End-around borrow resolves within the same cycle.
// RQ23: Count decrements per shift, stops at zero.
`timescale 1ns/10ps

module shift_and_subtractive_adder (
   input  wire logic                              CORE_CLK_I,
   input  wire logic                              RESET_I,
   input  wire arith_pkg::phase_type              PHASE_I,
   input  wire logic [1:0]                        SHIFT_VARIANT_I,
   input  wire logic [arith_pkg::WORD_MSB:0]      DATA_I,

   input  wire logic                              CMD_A_CLEAR_I,
   input  wire logic                              CMD_Q_CLEAR_I,
   input  wire logic                              CMD_D_CLEAR_I,
   input  wire logic                              CMD_X_CLEAR_I,

   input  wire logic                              CMD_DATA_TO_A_I,
   input  wire logic                              CMD_DATA_TO_Q_I,
   input  wire logic                              CMD_OPERAND_LOAD_I,
   input  wire logic                              CMD_OPERAND_LOAD_CPL_I,

   input  wire logic                              CMD_A_TO_X_I,
   input  wire logic                              CMD_Q_TO_X_I,
   input  wire logic                              CMD_D_TO_X_I,

   input  wire logic                              CMD_QL1_TO_X_I,
   input  wire logic                              CMD_AL1_TO_X_I,
   input  wire logic                              CMD_QR1_TO_X_I,
   input  wire logic                              CMD_AR1_TO_X_I,

   input  wire logic                              CMD_X_TO_A_I,
   input  wire logic                              CMD_X_TO_Q_I,
   input  wire logic                              CMD_X_CPL_TO_D_I,
   input  wire logic                              CMD_ADDER_TO_A_I,
   input  wire logic                              CMD_ADDER_TO_S_I,

   input  wire logic                              CHAIN_CARRY_CLEAR_I,
   input  wire logic                              CHAIN_RECIRCULATE_I,

   input  wire logic                              SHIFT_COUNT_LOAD_I,
   input  wire logic [arith_pkg::SHIFT_CNT_W-1:0] SHIFT_COUNT_I,
   input  wire logic                              SHIFT_STEP_DONE_I,

   output logic      [arith_pkg::WORD_MSB:0]      ACCUM_O,
   output logic      [arith_pkg::WORD_MSB:0]      QUOTIENT_O,
   output logic      [arith_pkg::WORD_MSB:0]      OPERAND_O,
   output logic      [arith_pkg::WORD_MSB:0]      EXCHANGE_O,
   output logic      [arith_pkg::WORD_MSB:0]      SUM_O,

   output logic                                   ACC_BIT_CARRY_FLAG_O,
   output logic                                   SAVED_BIT_FLAG_O,

   output logic      [arith_pkg::SHIFT_CNT_W-1:0] SHIFT_COUNT_O,
   output logic                                   SHIFT_COUNT_ZERO_O
);
   import arith_pkg::*;

   // =========================================================================
   // Storage and decoded controls.
   logic [WORD_MSB:0] accum;
   logic [WORD_MSB:0] quotient;
   logic [WORD_MSB:0] operand;
   logic [WORD_MSB:0] exchange;
   logic [WORD_MSB:0] sum_reg;

   logic              acc_bit_carry_flag;
   logic              saved_bit_flag;

   logic [WORD_MSB:0] adder_sum;
   logic [WORD_MSB:0] next_exchange;
   xsrc_type          xsrc;

   logic              phase_one;
   logic              phase_two;
   logic              phase_three;
   logic              phase_four;

   logic              j_quotient;
   logic              j_accum;
   logic              j_double;
   logic              j_muldiv;

   logic              carry_set;
   logic              saved_set;

   assign phase_one   = (PHASE_I == PH_ONE);
   assign phase_two   = (PHASE_I == PH_TWO);
   assign phase_three = (PHASE_I == PH_THREE);
   assign phase_four  = (PHASE_I == PH_FOUR);

   assign j_quotient = (SHIFT_VARIANT_I == J_QUOTIENT);
   assign j_accum    = (SHIFT_VARIANT_I == J_ACCUM);
   assign j_double   = (SHIFT_VARIANT_I == J_DOUBLE);
   assign j_muldiv   = (SHIFT_VARIANT_I == J_MULDIV);

   // =========================================================================
   // Adder, fed straight from the exchange and operand registers.
   subtractive_adder u_adder (
      .minuend_i (exchange),
      .operand_i (operand),
      .sum_o     (adder_sum)
   ); // RQ17

   // =========================================================================
   // Exchange register source selection, one command at a time.
   always_comb begin
      if (CMD_QL1_TO_X_I) begin
         xsrc = XSRC_QL1;
      end else if (CMD_AL1_TO_X_I) begin
         xsrc = XSRC_AL1;
      end else if (CMD_QR1_TO_X_I) begin
         xsrc = XSRC_QR1;
      end else if (CMD_AR1_TO_X_I) begin
         xsrc = XSRC_AR1;
      end else if (CMD_A_TO_X_I) begin
         xsrc = XSRC_A;
      end else if (CMD_Q_TO_X_I) begin
         xsrc = XSRC_Q;
      end else if (CMD_D_TO_X_I) begin
         xsrc = XSRC_D;
      end else begin
         xsrc = XSRC_HOLD;
      end
   end

   // =========================================================================
   // Shift paths into the exchange register.
   always_comb begin
      next_exchange = exchange;

      case (xsrc)
         XSRC_A: begin
            next_exchange = accum;
         end

         XSRC_Q: begin
            next_exchange = quotient;
         end

         XSRC_D: begin
            next_exchange = operand;
         end

         XSRC_QL1: begin
            next_exchange[WORD_MSB:1] = quotient[WORD_MSB-1:0];
            if (j_muldiv) begin
               next_exchange[WORD_LSB] = 1'b0; // RQ11
            end else if (j_double) begin
               next_exchange[WORD_LSB] = accum[WORD_MSB]; // RQ4
            end else begin
               next_exchange[WORD_LSB] = quotient[WORD_MSB]; // RQ1
            end
         end

         XSRC_AL1: begin
            next_exchange[WORD_MSB:1] = accum[WORD_MSB-1:0];
            if (j_accum || j_quotient) begin
               next_exchange[WORD_LSB] = accum[WORD_MSB]; // RQ2
            end else begin
               // The saved bit only reaches bit 0 once the carry flag is gone.
               next_exchange[WORD_LSB] = saved_bit_flag & ~acc_bit_carry_flag; // RQ6
            end
         end

         XSRC_QR1: begin
            next_exchange[WORD_MSB-1:0] = quotient[WORD_MSB:1];
            if (j_quotient) begin
               next_exchange[WORD_MSB] = quotient[WORD_MSB];
            end else begin
               // Combined right shift: accumulator bit 0 drops into the top.
               next_exchange[WORD_MSB] = accum[WORD_LSB];
            end
         end

         XSRC_AR1: begin
            next_exchange[WORD_MSB-1:0] = accum[WORD_MSB:1];
            if (j_muldiv) begin
               next_exchange[WORD_MSB] = 1'b0; // RQ10
            end else begin
               next_exchange[WORD_MSB] = accum[WORD_MSB];
            end
         end

         XSRC_HOLD: begin
            next_exchange = exchange;
         end

         default: begin
            next_exchange = exchange;
         end
      endcase
   end

   // =========================================================================
   // Exchange register: cleared to ones in phase four, loaded in phase one.
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         exchange <= X_CLEARED_VALUE;
      end else if (phase_four && CMD_X_CLEAR_I) begin
         exchange <= X_CLEARED_VALUE; // RQ20
      end else if (phase_one && (xsrc != XSRC_HOLD)) begin
         exchange <= next_exchange; // RQ20
      end
   end

   // =========================================================================
   // Helper flags. A set in the same cycle as a clear wins.
   assign carry_set = phase_one && CMD_QL1_TO_X_I
                      && ((j_double && accum[WORD_MSB]) || j_muldiv); // RQ11

   assign saved_set = phase_one
                      && ((CMD_QL1_TO_X_I && (j_double || j_muldiv)
                           && quotient[WORD_MSB])                       // RQ3
                          || (CMD_QR1_TO_X_I && j_muldiv
                              && quotient[WORD_LSB]));                  // RQ9

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         acc_bit_carry_flag <= FLAG_RESET_VALUE;
      end else if (carry_set) begin
         acc_bit_carry_flag <= 1'b1;
      end else if (CHAIN_CARRY_CLEAR_I) begin
         acc_bit_carry_flag <= 1'b0; // RQ5
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         saved_bit_flag <= FLAG_RESET_VALUE;
      end else if (saved_set) begin
         saved_bit_flag <= 1'b1;
      end else if (CHAIN_RECIRCULATE_I) begin
         saved_bit_flag <= 1'b0; // RQ7
      end
   end

   // =========================================================================
   // Accumulator: cleared in phase two, loaded in phase three.
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         accum <= REG_RESET_VALUE;
      end else if (phase_two && CMD_A_CLEAR_I) begin
         accum <= REG_RESET_VALUE;
      end else if (phase_three && CMD_ADDER_TO_A_I) begin
         accum <= adder_sum; // RQ18
      end else if (phase_three && CMD_X_TO_A_I) begin
         accum <= exchange;
      end else if (phase_three && CMD_DATA_TO_A_I) begin
         accum <= DATA_I;
      end
   end

   // =========================================================================
   // Quotient register.
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         quotient <= REG_RESET_VALUE;
      end else if (phase_two && CMD_Q_CLEAR_I) begin
         quotient <= REG_RESET_VALUE;
      end else if (phase_three && CMD_X_TO_Q_I) begin
         quotient <= exchange; // RQ4
      end else if (phase_three && CMD_DATA_TO_Q_I) begin
         quotient <= DATA_I;
      end
   end

   // =========================================================================
   // Operand register; subtract enters the complement.
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         operand <= REG_RESET_VALUE;
      end else if (phase_two && CMD_D_CLEAR_I) begin
         operand <= REG_RESET_VALUE;
      end else if (phase_three && CMD_OPERAND_LOAD_CPL_I) begin
         operand <= ~DATA_I; // RQ21
      end else if (phase_three && CMD_OPERAND_LOAD_I) begin
         operand <= DATA_I; // RQ19
      end else if (phase_three && CMD_X_CPL_TO_D_I) begin
         operand <= ~exchange;
      end
   end

   // =========================================================================
   // Sum register.
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         sum_reg <= REG_RESET_VALUE;
      end else if (phase_three && CMD_ADDER_TO_S_I) begin
         sum_reg <= adder_sum; // RQ18
      end
   end

   // =========================================================================
   // Remaining count of double-length shift steps.
   shift_counter u_shift_counter (
      .clk_i   (CORE_CLK_I),
      .reset_i (RESET_I),
      .load_i  (SHIFT_COUNT_LOAD_I),
      .count_i (SHIFT_COUNT_I),
      .step_i  (SHIFT_STEP_DONE_I),
      .count_o (SHIFT_COUNT_O),
      .zero_o  (SHIFT_COUNT_ZERO_O)
   ); // RQ8 RQ23

   // =========================================================================
   // Outputs.
   assign ACCUM_O              = accum;
   assign QUOTIENT_O           = quotient;
   assign OPERAND_O            = operand;
   assign EXCHANGE_O           = exchange;

   assign SUM_O                = sum_reg;

   assign ACC_BIT_CARRY_FLAG_O = acc_bit_carry_flag;
   assign SAVED_BIT_FLAG_O     = saved_bit_flag;

endmodule // shift_and_subtractive_adder

/* File: design/arith_pkg.sv */
package arith_pkg;

   // ==========================================================================
   // Word layout.
   localparam int unsigned WORD_W      = 15;
   localparam int unsigned WORD_MSB    = 14;
   localparam int unsigned WORD_LSB    = 0;
   localparam int unsigned SHIFT_CNT_W = 5;

   // ==========================================================================
   // Reset values.
   localparam logic [14:0] REG_RESET_VALUE   = 15'h0000;
   localparam logic [14:0] X_CLEARED_VALUE   = 15'h7FFF;
   localparam logic [4:0]  COUNT_RESET_VALUE = 5'h00;
   localparam logic        FLAG_RESET_VALUE  = 1'b0;

   // ==========================================================================
   // Shift-variant field encodings.
   localparam logic [1:0] J_QUOTIENT = 2'h0;
   localparam logic [1:0] J_ACCUM    = 2'h1;
   localparam logic [1:0] J_DOUBLE   = 2'h2;
   localparam logic [1:0] J_MULDIV   = 2'h3;

   // ==========================================================================
   // Clock phases of the sequencer.
   typedef enum logic [1:0] {
      PH_ONE   = 2'b00,
      PH_TWO   = 2'b01,
      PH_THREE = 2'b10,
      PH_FOUR  = 2'b11
   } phase_type;

   // ==========================================================================
   // Sources of the exchange register.
   typedef enum logic [2:0] {
      XSRC_HOLD  = 3'b000,
      XSRC_A     = 3'b001,
      XSRC_QL1   = 3'b010,
      XSRC_AL1   = 3'b011,
      XSRC_QR1   = 3'b100,
      XSRC_AR1   = 3'b101,
      XSRC_D     = 3'b110,
      XSRC_Q     = 3'b111
   } xsrc_type;

endpackage : arith_pkg

/* File: design/subtractive_adder.sv */
`timescale 1ns/10ps

// ============================================================================
// Fifteen identical subtractive stages with end-around borrow.
module subtractive_adder (
   input  wire logic [arith_pkg::WORD_MSB:0] minuend_i,
   input  wire logic [arith_pkg::WORD_MSB:0] operand_i,
   output logic      [arith_pkg::WORD_MSB:0] sum_o
);
   import arith_pkg::*;

   logic [WORD_MSB:0] operand_cpl;
   logic [WORD_MSB:0] per_bit_difference;
   logic [WORD_MSB:0] request;
   logic [WORD_MSB:0] enable;
   logic [WORD_MSB:0] borrow_row;

   // Walks down past bit 0 until a stage lends or asks a borrow.
   function automatic logic borrow_into(input logic [14:0] req,
                                        input logic [14:0] ena,
                                        input int unsigned  pos);
      logic hit;
      logic done;
      int unsigned k;
      hit  = 1'b0;
      done = 1'b0;
      for (int unsigned step = 1; step <= WORD_W; step++) begin
         k = (pos + WORD_W - step) % WORD_W;
         if (!done && ena[k]) begin
            done = 1'b1;
         end else if (!done && req[k]) begin
            hit  = 1'b1;
            done = 1'b1;
         end
      end
      return hit;
   endfunction

   assign operand_cpl = ~operand_i; // RQ19

   for (genvar i = 0; i < WORD_W; i++) begin : g_stage
      assign per_bit_difference[i] = minuend_i[i] ^ operand_cpl[i]; // RQ14
      assign request[i]            = ~minuend_i[i] & operand_cpl[i];
      assign enable[i]             = minuend_i[i] & ~operand_cpl[i];
      assign borrow_row[i]         = borrow_into(request, enable, i); // RQ15 RQ13 RQ22
      assign sum_o[i]              = per_bit_difference[i] ^ borrow_row[i]; // RQ16 RQ12
   end

endmodule // subtractive_adder

/* File: design/shift_counter.sv */
`timescale 1ns/10ps

// ============================================================================
// Remaining count of one-place double-length shifts.
module shift_counter (
   input  wire logic                             clk_i,
   input  wire logic                             reset_i,
   input  wire logic                             load_i,
   input  wire logic [arith_pkg::SHIFT_CNT_W-1:0] count_i,
   input  wire logic                             step_i,
   output logic      [arith_pkg::SHIFT_CNT_W-1:0] count_o,
   output logic                                  zero_o
);
   import arith_pkg::*;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count_o <= COUNT_RESET_VALUE;
      end else if (load_i) begin
         count_o <= count_i;
      end else if (step_i && (count_o != COUNT_RESET_VALUE)) begin
         count_o <= count_o - 5'h01; // RQ23
      end
   end

   assign zero_o = (count_o == COUNT_RESET_VALUE); // RQ8

endmodule // shift_counter

/* File: dv/control_sequencer.sv */
`timescale 1ns/10ps

// ==========
// Rotates the clock phases and runs double-length left shifts.
module control_sequencer (
   input  wire logic            clk_i,
   input  wire logic            reset_i,
   input  wire logic            go_i,
   input  wire logic            zero_i,
   output arith_pkg::phase_type phase_o,
   output logic                 busy_o,
   output logic      [23:0]     cmd_o
);
   import arith_pkg::*;

   logic half;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         phase_o <= PH_ONE;
      end else begin
         phase_o <= phase_type'(phase_o + 2'h1);
      end
   end

   // Runs start at phase four, so the quotient half comes first.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         busy_o <= 1'b0;
         half   <= 1'b0;
      end else if (go_i && phase_o == PH_FOUR) begin
         busy_o <= 1'b1;
         half   <= 1'b0;
      end else if (busy_o && phase_o == PH_THREE) begin
         half <= ~half;
      end else if (busy_o && phase_o == PH_FOUR && !half && zero_i) begin
         busy_o <= 1'b0;
      end
   end

   always_comb begin
      cmd_o     = 24'h000000;
      cmd_o[3]  = busy_o && phase_o == PH_FOUR;
      cmd_o[11] = busy_o && !half && phase_o == PH_ONE;
      cmd_o[16] = busy_o && !half && phase_o == PH_THREE;
      cmd_o[20] = cmd_o[16];
      cmd_o[12] = busy_o && half && phase_o == PH_ONE;
      cmd_o[15] = busy_o && half && phase_o == PH_THREE;
      cmd_o[21] = cmd_o[15];
      cmd_o[23] = cmd_o[15];
   end
endmodule // control_sequencer

/* File: dv/shift_and_subtractive_adder_asserts.sv */
`timescale 1ns/10ps

module arith_checker (
   input logic                 CORE_CLK_I,
   input logic                 RESET_I,
   input arith_pkg::phase_type PHASE_I,
   input logic [1:0]           SHIFT_VARIANT_I,
   input logic                 CMD_QL1_TO_X_I,
   input logic                 CMD_AL1_TO_X_I,
   input logic                 CMD_QR1_TO_X_I,
   input logic                 CMD_AR1_TO_X_I,
   input logic                 CMD_ADDER_TO_S_I,
   input logic                 CHAIN_CARRY_CLEAR_I,
   input logic                 CHAIN_RECIRCULATE_I,
   input logic                 SHIFT_COUNT_LOAD_I,
   input logic                 SHIFT_STEP_DONE_I,
   input logic [14:0]          ACCUM_O,
   input logic [14:0]          QUOTIENT_O,
   input logic [14:0]          EXCHANGE_O,
   input logic [14:0]          SUM_O,
   input logic                 ACC_BIT_CARRY_FLAG_O,
   input logic                 SAVED_BIT_FLAG_O,
   input logic [4:0]           SHIFT_COUNT_O
);
   import arith_pkg::*;

   logic        ph1;
   logic        ql1;
   logic        al1;
   logic [14:0] a_d;
   logic [14:0] q_d;
   logic [4:0]  c_d;

   assign ph1 = (PHASE_I == PH_ONE);
   assign ql1 = ph1 && CMD_QL1_TO_X_I;
   assign al1 = ph1 && CMD_AL1_TO_X_I && !CMD_QL1_TO_X_I;

   always_ff @(posedge CORE_CLK_I) begin
      a_d <= ACCUM_O;
      q_d <= QUOTIENT_O;
      c_d <= SHIFT_COUNT_O;
   end

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RESET_I);

   a_ql1_wrap: assert property (ql1 && SHIFT_VARIANT_I == J_QUOTIENT
      |=> EXCHANGE_O == {q_d[13:0], q_d[14]}) else $error("q left no wrap");
   a_al1_wrap: assert property (al1 && SHIFT_VARIANT_I == J_ACCUM
      |=> EXCHANGE_O == {a_d[13:0], a_d[14]}) else $error("a left no wrap");
   a_q14_saved: assert property (ql1 && SHIFT_VARIANT_I[1] && QUOTIENT_O[14]
      |=> SAVED_BIT_FLAG_O) else $error("q14 not saved");
   a_dbl_q_shift: assert property (ql1 && SHIFT_VARIANT_I == J_DOUBLE
      |=> EXCHANGE_O == {q_d[13:0], a_d[14]}) else $error("double q shift");
   a_carry_clear: assert property (CHAIN_CARRY_CLEAR_I && !ql1
      |=> !ACC_BIT_CARRY_FLAG_O) else $error("carry not cleared");
   a_dbl_a_zero: assert property (al1 && SHIFT_VARIANT_I == J_DOUBLE && SAVED_BIT_FLAG_O
      && !ACC_BIT_CARRY_FLAG_O |=> EXCHANGE_O == {a_d[13:0], 1'h1})
      else $error("saved bit lost");
   a_recirc_clear: assert property (CHAIN_RECIRCULATE_I && !ql1 && !(ph1 && CMD_QR1_TO_X_I)
      |=> !SAVED_BIT_FLAG_O) else $error("saved not cleared");
   a_mul_q0_save: assert property (ph1 && CMD_QR1_TO_X_I && SHIFT_VARIANT_I == J_MULDIV
      && QUOTIENT_O[0] |=> SAVED_BIT_FLAG_O) else $error("q0 not captured");
   a_mul_no_sign: assert property (ph1 && CMD_AR1_TO_X_I && !CMD_QL1_TO_X_I
      && !CMD_AL1_TO_X_I && !CMD_QR1_TO_X_I && SHIFT_VARIANT_I == J_MULDIV
      |=> EXCHANGE_O == {1'h0, a_d[14:1]}) else $error("sign extended");
   a_div_force: assert property (ql1 && SHIFT_VARIANT_I == J_MULDIV
      |=> ACC_BIT_CARRY_FLAG_O && !EXCHANGE_O[0]) else $error("bit 0 not forced");
   a_sum_hold: assert property (!(CMD_ADDER_TO_S_I && PHASE_I == PH_THREE)
      |=> $stable(SUM_O)) else $error("sum changed");
   a_count_step: assert property (SHIFT_STEP_DONE_I && !SHIFT_COUNT_LOAD_I
      && SHIFT_COUNT_O != 5'h00 |=> SHIFT_COUNT_O == c_d - 5'h01)
      else $error("count not stepped");

   c_double: cover property (ql1 && SHIFT_VARIANT_I == J_DOUBLE);
   c_sum: cover property (CMD_ADDER_TO_S_I && PHASE_I == PH_THREE);
   c_step: cover property (SHIFT_STEP_DONE_I && SHIFT_COUNT_O == 5'h01);
endmodule // arith_checker

bind shift_and_subtractive_adder arith_checker u_chk (.*);

/* File: dv/shift_and_subtractive_adder_tb.sv */
`timescale 1ns/10ps

module shift_and_subtractive_adder_tb;
   import arith_pkg::*;

   logic        clk;
   logic        rst;
   logic        go;
   logic        busy;
   phase_type   ph;
   logic [1:0]  j;
   logic [14:0] din;
   logic [4:0]  cnt_in;
   logic [23:0] tb_cmd;
   logic [23:0] seq_cmd;
   logic [23:0] cmd;
   logic [14:0] a_o, q_o, d_o, x_o, s_o;
   logic        carry, saved, zero;
   logic [4:0]  cnt_o;
   logic [29:0] aq;
   int          err_total, n_checks, cycles;
   logic [14:0] xv [4] = '{15'h0005, 15'h7FFF, 15'h4000, 15'h1234};
   logic [14:0] yv [4] = '{15'h0005, 15'h0000, 15'h4000, 15'h0F0F};

   assign cmd = tb_cmd | seq_cmd;

   shift_and_subtractive_adder u_dut (
      .CORE_CLK_I(clk), .RESET_I(rst), .PHASE_I(ph), .SHIFT_VARIANT_I(j), .DATA_I(din),
      .CMD_A_CLEAR_I(cmd[0]), .CMD_Q_CLEAR_I(cmd[1]), .CMD_D_CLEAR_I(cmd[2]),
      .CMD_X_CLEAR_I(cmd[3]), .CMD_DATA_TO_A_I(cmd[4]), .CMD_DATA_TO_Q_I(cmd[5]),
      .CMD_OPERAND_LOAD_I(cmd[6]), .CMD_OPERAND_LOAD_CPL_I(cmd[7]), .CMD_A_TO_X_I(cmd[8]),
      .CMD_Q_TO_X_I(cmd[9]), .CMD_D_TO_X_I(cmd[10]), .CMD_QL1_TO_X_I(cmd[11]),
      .CMD_AL1_TO_X_I(cmd[12]), .CMD_QR1_TO_X_I(cmd[13]), .CMD_AR1_TO_X_I(cmd[14]),
      .CMD_X_TO_A_I(cmd[15]), .CMD_X_TO_Q_I(cmd[16]), .CMD_X_CPL_TO_D_I(cmd[17]),
      .CMD_ADDER_TO_A_I(cmd[18]), .CMD_ADDER_TO_S_I(cmd[19]), .CHAIN_CARRY_CLEAR_I(cmd[20]),
      .CHAIN_RECIRCULATE_I(cmd[21]), .SHIFT_COUNT_LOAD_I(cmd[22]), .SHIFT_COUNT_I(cnt_in),
      .SHIFT_STEP_DONE_I(cmd[23]), .ACCUM_O(a_o), .QUOTIENT_O(q_o), .OPERAND_O(d_o),
      .EXCHANGE_O(x_o), .SUM_O(s_o), .ACC_BIT_CARRY_FLAG_O(carry), .SAVED_BIT_FLAG_O(saved),
      .SHIFT_COUNT_O(cnt_o), .SHIFT_COUNT_ZERO_O(zero)
   );

   control_sequencer u_seq (
      .clk_i(clk), .reset_i(rst), .go_i(go), .zero_i(zero), .phase_o(ph), .busy_o(busy),
      .cmd_o(seq_cmd)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========
   // Helpers.
   function automatic logic [23:0] b(input int k);
      return 24'h000001 << k;
   endfunction

   // One's complement difference with end-around borrow.
   function automatic logic [14:0] sub_eab(input logic [14:0] x, input logic [14:0] s);
      logic [15:0] r;
      r = {1'b0, x} - {1'b0, s};
      if (r[15]) r = r - 16'h0001;
      return r[14:0];
   endfunction

   task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Raises the commands for the one cycle of phase p.
   task automatic issue(input logic [23:0] m, input phase_type p);
      @(posedge clk);
      while (ph !== phase_type'(p - 2'h1)) @(posedge clk);
      tb_cmd <= m;
      @(posedge clk);
      tb_cmd <= 24'h000000;
      @(posedge clk);
   endtask

   task automatic load_aq(input logic [14:0] a, input logic [14:0] q);
      din <= a;
      issue(b(4), PH_THREE);
      din <= q;
      issue(b(5), PH_THREE);
   endtask

   task automatic wrap_up();
      if (err_total == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         wrap_up();
      end
   end

   // ==========
   // Scenarios.
   initial begin
      rst = 1'b1;
      go = 1'b0;
      j = J_QUOTIENT;
      din = 15'h0000;
      cnt_in = 5'h00;
      tb_cmd = 24'h000000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      check("reset exchange", x_o, X_CLEARED_VALUE);
      check("reset sum", s_o, REG_RESET_VALUE);
      check("reset zero", zero, 1'b1);
      foreach (xv[i]) begin
         load_aq(xv[i], 15'h0000);
         din <= yv[i];
         issue(b(6), PH_THREE);
         issue(b(8), PH_ONE);
         issue(b(19), PH_THREE);
         check("sum", s_o, sub_eab(xv[i], ~yv[i]));
         check("accum held", a_o, xv[i]);
         din <= yv[i];
         issue(b(7), PH_THREE);
         check("operand cpl", d_o, ~yv[i]);
         issue(b(18), PH_THREE);
         check("difference", a_o, sub_eab(xv[i], yv[i]));
      end
      issue(b(19), PH_ONE);
      check("sum refused", s_o, sub_eab(xv[3], ~yv[3]));
      issue(b(3), PH_FOUR);
      check("exchange clear", x_o, X_CLEARED_VALUE);
      load_aq(15'h4001, 15'h4003);
      issue(b(11), PH_ONE);
      check("quotient left", x_o, 15'h0007);
      j <= J_ACCUM;
      issue(b(12), PH_ONE);
      check("accum left", x_o, 15'h0003);
      j <= J_MULDIV;
      issue(b(13), PH_ONE);
      check("mul saved", saved, 1'b1);
      issue(b(14), PH_ONE);
      check("mul accum right", x_o, 15'h2000);
      issue(b(21), PH_TWO);
      check("saved cleared", saved, 1'b0);
      issue(b(11), PH_ONE);
      check("div carry", carry, 1'b1);
      check("div exchange", x_o, 15'h0006);
      check("div saved", saved, 1'b1);
      issue(b(20), PH_TWO);
      check("carry cleared", carry, 1'b0);
      load_aq(15'h6001, 15'h4005);
      j <= J_DOUBLE;
      cnt_in <= 5'h03;
      issue(b(22), PH_TWO);
      go <= 1'b1;
      @(posedge clk);
      while (!busy) @(posedge clk);
      go <= 1'b0;
      for (int k = 0; k < 200 && busy; k++) @(posedge clk);
      @(posedge clk);
      aq = {15'h6001, 15'h4005};
      repeat (3) aq = {aq[28:0], aq[29]};
      check("double accum", a_o, aq[29:15]);
      check("double quotient", q_o, aq[14:0]);
      check("count", cnt_o, 5'h00);
      check("count zero", zero, 1'b1);
      issue(b(9), PH_ONE);
      check("q to x", x_o, aq[14:0]);
      issue(b(17), PH_THREE);
      check("x cpl to d", d_o, ~aq[14:0]);
      issue(b(10), PH_ONE);
      check("d to x", x_o, ~aq[14:0]);
      issue(b(0) | b(1) | b(2), PH_TWO);
      check("cleared", a_o | q_o | d_o, REG_RESET_VALUE);
      wrap_up();
   end
endmodule // shift_and_subtractive_adder_tb
